/* dlc_pkg.sv */
`default_nettype none

package dlc_pkg;

	// ----------------------------------------------------------------
	// sizes
	// ----------------------------------------------------------------
	localparam int NCH       = 4;
	localparam int CHW       = 2;
	localparam int BCW       = 20;
	localparam int ADDRW     = 8;
	localparam int WRAP_BIAS = 3;

	// ----------------------------------------------------------------
	// register map (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [3:0]       OFS_CTRL      = 4'h0;
	localparam logic [3:0]       OFS_BCOUNT    = 4'h4;
	localparam logic [3:0]       OFS_DADDR     = 4'h8;
	localparam logic [3:0]       OFS_STAT      = 4'hc;
	localparam logic [ADDRW-1:0] ADDR_IRQ_STAT = 8'h40;
	localparam logic [ADDRW-1:0] ADDR_IRQ_MASK = 8'h44;

	// channel status word bit positions
	localparam int ST_DONE = 0;
	localparam int ST_CE   = 1;
	localparam int ST_BUSY = 2;
	localparam int ST_PEND = 3;

	// interrupt status: done flags low nibble, config errors high nibble
	localparam int IRQ_DONE_LSB = 0;
	localparam int IRQ_CE_LSB   = 4;

	// ----------------------------------------------------------------
	// codes
	// ----------------------------------------------------------------
	localparam logic [1:0] LINK_NONE    = 2'h0;
	localparam logic [1:0] LINK_EACH_LAST = 2'h1;
	localparam logic [1:0] LINK_EACH    = 2'h2;
	localparam logic [1:0] LINK_LAST    = 2'h3;
	localparam logic [1:0] RESP_OKAY    = 2'h0;
	localparam logic [1:0] RESP_SLVERR  = 2'h2;

	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [16:0] zero;
		logic        start;
		logic        peripheral_request_enable;
		logic        cycle_steal;
		logic [3:0]  destination_wrap_size;
		logic        auto_disable;
		logic        rsvd;
		logic [1:0]  link_condition_select;
		logic [1:0]  first_linked_channel;
		logic [1:0]  second_linked_channel;
	} dlc_ctrl_t;

	localparam dlc_ctrl_t CTRL_RST = '0;

	typedef enum logic {ENG_IDLE, ENG_XFER} dlc_eng_t;

endpackage

`default_nettype wire

/* dlc_top.sv */
`timescale 1ns/1ps
`default_nettype none

module dlc_top (
	// clock and reset
	input  wire logic                         aclk,
	input  wire logic                         aresetn,
	// axi4-lite write address
	input  wire logic                         s_axi_awvalid,
	output logic                              s_axi_awready,
	input  wire logic [dlc_pkg::ADDRW-1:0]    s_axi_awaddr,
	input  wire logic [2:0]                   s_axi_awprot,
	// axi4-lite write data
	input  wire logic                         s_axi_wvalid,
	output logic                              s_axi_wready,
	input  wire logic [31:0]                  s_axi_wdata,
	input  wire logic [3:0]                   s_axi_wstrb,
	// axi4-lite write response
	output logic                              s_axi_bvalid,
	input  wire logic                         s_axi_bready,
	output logic [1:0]                        s_axi_bresp,
	// axi4-lite read
	input  wire logic                         s_axi_arvalid,
	output logic                              s_axi_arready,
	input  wire logic [dlc_pkg::ADDRW-1:0]    s_axi_araddr,
	input  wire logic [2:0]                   s_axi_arprot,
	output logic                              s_axi_rvalid,
	input  wire logic                         s_axi_rready,
	output logic [31:0]                       s_axi_rdata,
	output logic [1:0]                        s_axi_rresp,
	// peripheral requests (asynchronous) and link pulses
	input  wire logic [dlc_pkg::NCH-1:0]      periph_req,
	output logic      [dlc_pkg::NCH-1:0]      link_req,
	// interrupt
	output logic                              irq
);

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
		input logic [3:0] strb);
		logic [31:0] r;
		r = old_v;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				r[i*8 +: 8] = new_v[i*8 +: 8];
			end
		end
		return r;
	endfunction

	function automatic logic mapped(input logic [dlc_pkg::ADDRW-1:0] a);
		return (a[7:6] == 2'h0) || ({a[7:2], 2'h0} == dlc_pkg::ADDR_IRQ_STAT) ||
			({a[7:2], 2'h0} == dlc_pkg::ADDR_IRQ_MASK);
	endfunction

	// code 0 is a plain increment; code n keeps the address inside a 2^(n+3) byte ring
	function automatic logic [31:0] wrap_next(input logic [31:0] a, input logic [3:0] code);
		logic [31:0] m;
		m = (32'h1 << (5'(code) + 5'(dlc_pkg::WRAP_BIAS))) - 32'h1;
		if (code == 4'h0) begin
			return a + 32'h1;
		end
		return (a & ~m) | ((a + 32'h1) & m);
	endfunction

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	dlc_pkg::dlc_ctrl_t          ctrl_q [dlc_pkg::NCH];
	dlc_pkg::dlc_ctrl_t          ctrl_d [dlc_pkg::NCH];
	logic [dlc_pkg::BCW-1:0]     bc_q   [dlc_pkg::NCH];
	logic [dlc_pkg::BCW-1:0]     bc_d   [dlc_pkg::NCH];
	logic [31:0]                 da_q   [dlc_pkg::NCH];
	logic [31:0]                 da_d   [dlc_pkg::NCH];
	logic [dlc_pkg::NCH-1:0]     done_q, done_d, ce_q, ce_d, pend_q, pend_d;
	logic [dlc_pkg::NCH-1:0]     link_q, link_d, sync1_q, sync1_d, sync2_q, sync2_d;
	logic [7:0]                  mask_q, mask_d;
	dlc_pkg::dlc_eng_t           state_q, state_d;
	logic [dlc_pkg::CHW-1:0]     cur_q, cur_d;

	logic                        aw_v_q, aw_v_d, w_v_q, w_v_d, b_v_q, b_v_d, r_v_q, r_v_d;
	logic [dlc_pkg::ADDRW-1:0]   aw_a_q, aw_a_d;
	logic [31:0]                 w_d_q, w_d_d, r_d_q, r_d_d;
	logic [3:0]                  w_s_q, w_s_d;
	logic [1:0]                  b_r_q, b_r_d, r_r_q, r_r_d;

	logic                        wr_go;
	logic                        found;
	logic [dlc_pkg::CHW-1:0]     gnt, wch;
	logic [dlc_pkg::BCW-1:0]     bc_n;
	dlc_pkg::dlc_ctrl_t          nc, cc;
	logic [31:0]                 rd_v;

	assign s_axi_awready = !aw_v_q;
	assign s_axi_wready  = !w_v_q;
	assign s_axi_bvalid  = b_v_q;
	assign s_axi_bresp   = b_r_q;
	assign s_axi_arready = !r_v_q;
	assign s_axi_rvalid  = r_v_q;
	assign s_axi_rdata   = r_d_q;
	assign s_axi_rresp   = r_r_q;
	assign link_req      = link_q;
	assign irq           = |({ce_q, done_q} & mask_q);
	// a held write commits only once the previous response has gone
	assign wr_go         = aw_v_q && w_v_q && !b_v_q;

	// ----------------------------------------------------------------
	// bus slave
	// ----------------------------------------------------------------
	always_comb begin
		aw_v_d = aw_v_q;
		aw_a_d = aw_a_q;
		w_v_d  = w_v_q;
		w_d_d  = w_d_q;
		w_s_d  = w_s_q;
		b_v_d  = b_v_q;
		b_r_d  = b_r_q;
		r_v_d  = r_v_q;
		r_d_d  = r_d_q;
		r_r_d  = r_r_q;
		rd_v   = 32'h0;
		if (s_axi_awvalid && !aw_v_q) begin
			aw_v_d = 1'b1;
			aw_a_d = s_axi_awaddr;
		end
		if (s_axi_wvalid && !w_v_q) begin
			w_v_d = 1'b1;
			w_d_d = s_axi_wdata;
			w_s_d = s_axi_wstrb;
		end
		if (b_v_q && s_axi_bready) begin
			b_v_d = 1'b0;
		end
		if (wr_go) begin
			aw_v_d = 1'b0;
			w_v_d  = 1'b0;
			b_v_d  = 1'b1;
			b_r_d  = mapped(aw_a_q) ? dlc_pkg::RESP_OKAY : dlc_pkg::RESP_SLVERR;
		end
		if (r_v_q && s_axi_rready) begin
			r_v_d = 1'b0;
		end
		if (s_axi_arvalid && !r_v_q) begin
			if (s_axi_araddr[7:6] == 2'h0) begin
				case (s_axi_araddr[3:0] & 4'hc)
					dlc_pkg::OFS_CTRL:   rd_v = ctrl_q[s_axi_araddr[5:4]];
					dlc_pkg::OFS_BCOUNT: rd_v = 32'(bc_q[s_axi_araddr[5:4]]);
					dlc_pkg::OFS_DADDR:  rd_v = da_q[s_axi_araddr[5:4]];
					default: begin
						rd_v[dlc_pkg::ST_DONE] = done_q[s_axi_araddr[5:4]];
						rd_v[dlc_pkg::ST_CE]   = ce_q[s_axi_araddr[5:4]];
						rd_v[dlc_pkg::ST_BUSY] = (state_q == dlc_pkg::ENG_XFER) &&
							(cur_q == s_axi_araddr[5:4]);
						rd_v[dlc_pkg::ST_PEND] = pend_q[s_axi_araddr[5:4]];
					end
				endcase
			end else if ({s_axi_araddr[7:2], 2'h0} == dlc_pkg::ADDR_IRQ_STAT) begin
				rd_v = {24'h0, ce_q, done_q};
			end else if ({s_axi_araddr[7:2], 2'h0} == dlc_pkg::ADDR_IRQ_MASK) begin
				rd_v = {24'h0, mask_q};
			end
			r_v_d = 1'b1;
			r_d_d = rd_v;
			r_r_d = mapped(s_axi_araddr) ? dlc_pkg::RESP_OKAY : dlc_pkg::RESP_SLVERR;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_v_q <= 1'b0;
			aw_a_q <= 8'h0;
			w_v_q  <= 1'b0;
			w_d_q  <= 32'h0;
			w_s_q  <= 4'h0;
			b_v_q  <= 1'b0;
			b_r_q  <= 2'h0;
			r_v_q  <= 1'b0;
			r_d_q  <= 32'h0;
			r_r_q  <= 2'h0;
		end else begin
			aw_v_q <= aw_v_d;
			aw_a_q <= aw_a_d;
			w_v_q  <= w_v_d;
			w_d_q  <= w_d_d;
			w_s_q  <= w_s_d;
			b_v_q  <= b_v_d;
			b_r_q  <= b_r_d;
			r_v_q  <= r_v_d;
			r_d_q  <= r_d_d;
			r_r_q  <= r_r_d;
		end
	end

	// ----------------------------------------------------------------
	// channels and transfer engine
	// ----------------------------------------------------------------
	always_comb begin
		ctrl_d  = ctrl_q;
		bc_d    = bc_q;
		da_d    = da_q;
		done_d  = done_q;
		ce_d    = ce_q;
		pend_d  = pend_q;
		mask_d  = mask_q;
		state_d = state_q;
		cur_d   = cur_q;
		link_d  = '0;
		sync1_d = periph_req;
		sync2_d = sync1_q;
		wch     = aw_a_q[5:4];
		nc      = dlc_pkg::CTRL_RST;
		cc      = ctrl_q[cur_q];
		bc_n    = bc_q[cur_q] - 20'h1;
		found   = 1'b0;
		gnt     = 2'h0;
		// software first, so a hardware set in the same cycle wins over a clear
		if (wr_go && mapped(aw_a_q)) begin
			if (aw_a_q[7:6] == 2'h0) begin
				case (aw_a_q[3:0] & 4'hc)
					dlc_pkg::OFS_CTRL: begin
						nc      = merge(ctrl_q[wch], w_d_q, w_s_q);
						nc.zero = '0;
						nc.rsvd = 1'b0;
						if (nc.start) begin
							pend_d[wch] = 1'b1;
						end
						nc.start    = 1'b0;
						ctrl_d[wch] = nc;
					end
					dlc_pkg::OFS_BCOUNT: bc_d[wch] = dlc_pkg::BCW'(merge(32'(bc_q[wch]), w_d_q, w_s_q));
					dlc_pkg::OFS_DADDR:  da_d[wch] = merge(da_q[wch], w_d_q, w_s_q);
					default: begin
						if (w_s_q[0] && w_d_q[dlc_pkg::ST_DONE]) begin
							done_d[wch] = 1'b0;
						end
						if (w_s_q[0] && w_d_q[dlc_pkg::ST_CE]) begin
							ce_d[wch] = 1'b0;
						end
					end
				endcase
			end else if ({aw_a_q[7:2], 2'h0} == dlc_pkg::ADDR_IRQ_STAT) begin
				if (w_s_q[0]) begin
					done_d = done_d & ~w_d_q[dlc_pkg::IRQ_DONE_LSB +: 4];
					ce_d   = ce_d & ~w_d_q[dlc_pkg::IRQ_CE_LSB +: 4];
				end
			end else if (w_s_q[0]) begin
				mask_d = w_d_q[7:0];
			end
		end
		for (int i = 0; i < dlc_pkg::NCH; i++) begin
			if (sync2_q[i] && ctrl_q[i].peripheral_request_enable) begin
				pend_d[i] = 1'b1;
			end
		end
		pend_d = pend_d | link_q;
		case (state_q)
			dlc_pkg::ENG_IDLE: begin
				// channel 0 has the highest priority
				for (int i = dlc_pkg::NCH - 1; i >= 0; i--) begin
					if (pend_q[i]) begin
						found = 1'b1;
						gnt   = dlc_pkg::CHW'(i);
					end
				end
				if (found) begin
					pend_d[gnt] = 1'b0;
					if (ctrl_q[gnt].link_condition_select != dlc_pkg::LINK_NONE &&
						(ctrl_q[gnt].first_linked_channel == gnt ||
						ctrl_q[gnt].second_linked_channel == gnt)) begin
						ce_d[gnt] = 1'b1;
					end else if (bc_q[gnt] == '0) begin
						done_d[gnt] = 1'b1;
					end else begin
						state_d = dlc_pkg::ENG_XFER;
						cur_d   = gnt;
					end
				end
			end
			dlc_pkg::ENG_XFER: begin
				bc_d[cur_q] = bc_n;
				da_d[cur_q] = wrap_next(da_q[cur_q], cc.destination_wrap_size);
				if (bc_n == '0) begin
					done_d[cur_q] = 1'b1;
					state_d       = dlc_pkg::ENG_IDLE;
					if (cc.auto_disable) begin
						ctrl_d[cur_q].peripheral_request_enable = 1'b0;
					end
					case (cc.link_condition_select)
						dlc_pkg::LINK_EACH_LAST: link_d[cc.second_linked_channel] = 1'b1;
						dlc_pkg::LINK_EACH: link_d[cc.first_linked_channel] = cc.cycle_steal;
						dlc_pkg::LINK_LAST: link_d[cc.first_linked_channel] = 1'b1;
						default: link_d = '0;
					endcase
				end else if (cc.cycle_steal) begin
					state_d = dlc_pkg::ENG_IDLE;
					if (cc.link_condition_select == dlc_pkg::LINK_EACH_LAST ||
						cc.link_condition_select == dlc_pkg::LINK_EACH) begin
						link_d[cc.first_linked_channel] = 1'b1;
					end
				end
			end
			default: state_d = dlc_pkg::ENG_IDLE;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			for (int i = 0; i < dlc_pkg::NCH; i++) begin
				ctrl_q[i] <= dlc_pkg::CTRL_RST;
				bc_q[i]   <= '0;
				da_q[i]   <= 32'h0;
			end
			done_q  <= 4'h0;
			ce_q    <= 4'h0;
			pend_q  <= 4'h0;
			link_q  <= 4'h0;
			sync1_q <= 4'h0;
			sync2_q <= 4'h0;
			mask_q  <= 8'h0;
			state_q <= dlc_pkg::ENG_IDLE;
			cur_q   <= 2'h0;
		end else begin
			ctrl_q  <= ctrl_d;
			bc_q    <= bc_d;
			da_q    <= da_d;
			done_q  <= done_d;
			ce_q    <= ce_d;
			pend_q  <= pend_d;
			link_q  <= link_d;
			sync1_q <= sync1_d;
			sync2_q <= sync2_d;
			mask_q  <= mask_d;
			state_q <= state_d;
			cur_q   <= cur_d;
		end
	end

endmodule // dlc_top

`default_nettype wire

/* dlc_props.sv */
`timescale 1ns/1ps
`default_nettype none

module dlc_props (
	// clock and reset
	input wire logic                    aclk,
	input wire logic                    aresetn,
	// register bus
	input wire logic                    s_axi_awvalid,
	input wire logic                    s_axi_awready,
	input wire logic                    s_axi_wvalid,
	input wire logic                    s_axi_wready,
	input wire logic                    s_axi_bvalid,
	input wire logic                    s_axi_bready,
	input wire logic [1:0]              s_axi_bresp,
	input wire logic                    s_axi_arvalid,
	input wire logic                    s_axi_arready,
	input wire logic                    s_axi_rvalid,
	input wire logic                    s_axi_rready,
	input wire logic [31:0]             s_axi_rdata,
	// link pulses and interrupt
	input wire logic [dlc_pkg::NCH-1:0] link_req,
	input wire logic                    irq
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	property p_rst;
		disable iff (1'b0) !aresetn |=> !s_axi_bvalid && !s_axi_rvalid && link_req == '0 && !irq;
	endproperty
	property p_pulse;
		link_req != '0 |-> $onehot0(link_req) ##1 link_req == '0;
	endproperty
	property p_bhold;
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
	endproperty
	property p_rhold;
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
	endproperty
	property p_arref;
		s_axi_rvalid |-> !s_axi_arready;
	endproperty
	property p_rlat;
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
	endproperty
	property p_blat;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && !s_axi_bvalid |-> ##2 s_axi_bvalid;
	endproperty
	property p_held;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> !s_axi_awready && !s_axi_wready;
	endproperty

	a_rst: assert property (p_rst) else $error("outputs not idle after reset");
	a_pulse: assert property (p_pulse) else $error("link pulse too wide");
	a_bhold: assert property (p_bhold) else $error("write response dropped");
	a_rhold: assert property (p_rhold) else $error("read data dropped");
	a_arref: assert property (p_arref) else $error("read address taken while busy");
	a_rlat: assert property (p_rlat) else $error("read answer late");
	a_blat: assert property (p_blat) else $error("write answer late");
	a_held: assert property (p_held) else $error("write channels not held");

	cover property (link_req != '0);
	cover property ($rose(irq));
	cover property (s_axi_bvalid && s_axi_bresp == dlc_pkg::RESP_SLVERR);
endmodule // dlc_props

`default_nettype wire

/* dlc_periph_src.sv */
`timescale 1ns/1ps
`default_nettype none

module dlc_periph_src (
	// clock
	input wire logic       aclk,
	// commands from the bench
	input wire logic [3:0] fire,
	input wire logic       slow,
	// request levels toward the engine
	output logic [3:0]     req
);
	logic [3:0] cnt [4] = '{default: 4'h0};

	// a slow source holds its request long after service, like a lazy peripheral
	always @(posedge aclk)
		for (int i = 0; i < 4; i++)
			if (fire[i])
				cnt[i] <= slow ? 4'hc : 4'h3;
			else if (cnt[i] != 4'h0)
				cnt[i] <= cnt[i] - 4'h1;

	always_comb
		for (int i = 0; i < 4; i++)
			req[i] = cnt[i] != 4'h0; // driven low between requests
endmodule // dlc_periph_src

`default_nettype wire

/* dma_channel_link_control_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none

module dma_channel_link_control_tb_top;
	logic aclk = 1'b0, aresetn = 1'b0, slow = 1'b0, irq;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [3:0] periph_req, link_req, fire = 4'h0;
	int err_count = 0, samples_checked = 0;
	int lc [4];

	dlc_top dlc_top_inst (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr,
		.s_axi_awprot(3'h0), .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb(4'hf),
		.s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr,
		.s_axi_arprot(3'h0), .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp,
		.periph_req, .link_req, .irq);
	dlc_periph_src dlc_periph_src_inst (.aclk, .fire, .slow, .req(periph_req));

	always #10 aclk = ~aclk;
	// count on the falling edge, so the pulse is read where it has settled
	always @(negedge aclk)
		for (int i = 0; i < 4; i++)
			lc[i] += int'(link_req[i]);

	task automatic summarize;
		if (err_count == 0 && samples_checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		samples_checked++;
		if (s !== e) begin
			err_count++;
			$display("[FAIL] %0t seen=%h exp=%h", $time, s, e);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		logic ta, tw, tb;
		@(posedge aclk);
		s_axi_awvalid <= 1'b1;
		s_axi_awaddr <= a;
		s_axi_wvalid <= 1'b1;
		s_axi_wdata <= d;
		s_axi_bready <= 1'b1;
		do begin
			@(negedge aclk);
			ta = s_axi_awvalid && s_axi_awready;
			tw = s_axi_wvalid && s_axi_wready;
			tb = s_axi_bvalid;
			r = s_axi_bresp;
			@(posedge aclk);
			if (ta) s_axi_awvalid <= 1'b0;
			if (tw) s_axi_wvalid <= 1'b0;
		end while (!tb);
		s_axi_bready <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		logic ta, tr;
		@(posedge aclk);
		s_axi_arvalid <= 1'b1;
		s_axi_araddr <= a;
		s_axi_rready <= 1'b1;
		do begin
			@(negedge aclk);
			ta = s_axi_arvalid && s_axi_arready;
			tr = s_axi_rvalid;
			d = s_axi_rdata;
			r = s_axi_rresp;
			@(posedge aclk);
			if (ta) s_axi_arvalid <= 1'b0;
		end while (!tr);
		s_axi_rready <= 1'b0;
	endtask

	task automatic w(input logic [7:0] a, input logic [31:0] d);
		logic [1:0] r;
		wr(a, d, r);
		chk(r, dlc_pkg::RESP_OKAY);
	endtask

	task automatic rg(input logic [7:0] a, output logic [31:0] d);
		logic [1:0] r;
		rd(a, d, r);
		chk(r, dlc_pkg::RESP_OKAY);
	endtask

	task automatic t_regs;
		logic [31:0] v;
		logic [1:0] r;
		rg(8'h00, v);
		chk(v, 32'h0);
		w(8'h00, 32'hffff_fff6);
		rg(8'h00, v);
		chk(v, 32'h0000_3fb6);
		w(8'h00, 32'h0);
		w(8'h0c, 32'h3);
		wr(8'h80, 32'h1, r);
		chk(r, dlc_pkg::RESP_SLVERR);
		rd(8'h80, v, r);
		chk(r, dlc_pkg::RESP_SLVERR);
		chk(v, 32'h0);
	endtask

	task automatic t_wrap(input logic [3:0] c);
		logic [31:0] a, sz, v;
		a = 32'h3fffe;
		sz = (c == 4'he) ? 32'h0002_0000 : 32'h0004_0000; // 128 KB or 256 KB ring
		w(8'h08, a);
		w(8'h04, 32'h2);
		w(8'h00, {17'h0, 2'b10, 1'b0, c, 8'h0});
		repeat (8) @(posedge aclk);
		rg(8'h08, v);
		chk(v, (a & ~(sz - 1)) | ((a + 2) & (sz - 1)));
		w(8'h0c, 32'h1);
	endtask

	// three transfers from channel 0, first link to 1, second link to 2
	task automatic t_link(input logic [1:0] cc, input logic cs);
		int e1, e2;
		logic [31:0] v;
		e1 = (cc == 2'h1 && cs) ? 2 : (cc == 2'h2 && cs) ? 3 : (cc == 2'h3) ? 1 : 0;
		e2 = (cc == 2'h1) ? 1 : 0;
		w(8'h04, 32'h3);
		lc = '{default: 0};
		repeat (cs ? 3 : 1) begin
			w(8'h00, {17'h0, 2'b10, cs, 6'h0, cc, 4'h6});
			repeat (6) @(posedge aclk);
		end
		chk(32'(lc[1]), 32'(e1));
		chk(32'(lc[2]), 32'(e2));
		chk(32'(lc[0] + lc[3]), 32'h0);
		rg(8'h04, v);
		chk(v, 32'h0);
		w(8'h0c, 32'h1);
	endtask

	task automatic t_cfg(input int f);
		logic [7:0] b, m;
		logic [1:0] ch;
		logic [31:0] v;
		ch = 2'(f + 1);
		b = {2'h0, ch, 4'h0};
		m = 8'h10 << ch;
		w(b + 8'h4, 32'h5);
		lc = '{default: 0};
		w(b, {17'h0, 2'b10, 7'h0, 2'h3, f ? {2'h0, ch} : {ch, 2'h0}});
		repeat (8) @(posedge aclk);
		rg(b + 8'hc, v);
		chk(v[1], 1'b1);
		rg(b + 8'h4, v);
		chk(v, 32'h5);
		chk(32'(lc[0] + lc[ch]), 32'h0);
		rg(8'h40, v);
		chk(v & m, m);
		chk(irq, 1'b0);
		w(8'h44, m);
		@(negedge aclk);
		chk(irq, 1'b1);
		w(8'h40, m);
		@(negedge aclk);
		chk(irq, 1'b0);
		w(8'h44, 32'h0);
		w(b + 8'hc, 32'h2);
		w(b, 32'h0);
	endtask

	// channel 3 served by the peripheral source in continuous mode
	task automatic t_auto(input logic au, input logic en);
		logic [31:0] v;
		w(8'h34, 32'h2);
		w(8'h30, {17'h0, 1'b0, en, 1'b0, 4'h0, au, 7'h0});
		slow <= en & ~au;
		fire <= 4'h8;
		@(posedge aclk);
		fire <= 4'h0;
		repeat (20) @(posedge aclk);
		rg(8'h30, v);
		chk(v[13], en & ~au);
		rg(8'h34, v);
		chk(v, en ? 32'h0 : 32'h2);
		w(8'h3c, 32'h1);
		w(8'h30, 32'h0);
	endtask

	initial begin
		#1_000_000;
		err_count++;
		summarize();
	end

	initial begin
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		t_regs();
		t_wrap(4'he);
		t_wrap(4'hf);
		for (int i = 0; i < 8; i++)
			t_link(2'(i >> 1), i[0]);
		t_cfg(0);
		t_cfg(1);
		t_auto(1'b1, 1'b1);
		t_auto(1'b0, 1'b1);
		t_auto(1'b1, 1'b0);
		summarize();
	end
endmodule // dma_channel_link_control_tb_top

bind dlc_top dlc_props dlc_props_inst (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
	.s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready,
	.s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .link_req, .irq);

`default_nettype wire
